// ---- hw/timer2_counter_reload_capture.sv ----
// Timer/counter with reload, capture channels and overflow/reload flags
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
module timer2_counter_reload_capture (
  input wire logic clk,
  input wire logic resetn,
  input wire timer2_pkg::bus_req_t bus,
  output logic [7:0] rdata,
  input wire timer2_pkg::pins_t pins,
  output logic irq,
  output logic [3:0] compare_match
);
  // Full state and its next value
  timer2_pkg::state_t st_r;
  timer2_pkg::state_t st_nxt;
  // Machine cycle strobe, one clock in six
  logic tick;
  // Counting decision for this machine cycle
  logic inc;
  // Detected pin events in this machine cycle
  logic count_fall;
  logic reload_fall;
  // Count plus one, wraps to zero from all ones
  logic [15:0] count_plus;
  // Increment that carries out of the top bit
  logic rollover;
  // Function select field of the control byte
  logic [1:0] insel;
  // Reload mode field of the control byte
  logic [1:0] rmode;

  // Mode field of channel n out of the packed mode byte
  function automatic logic [1:0] chan_mode_of(input logic [7:0] modes, input int n);
    chan_mode_of = modes[2*n +: 2];
  endfunction

  assign tick = (st_r.phase == timer2_pkg::MACHINE_LAST);
  assign insel = st_r.control[timer2_pkg::CTL_INSEL_LSB +: 2];
  assign rmode = st_r.control[timer2_pkg::CTL_RELOAD_LSB +: 2];
  // high then low in consecutive samples
  assign count_fall = tick && st_r.count_sample && !pins.count_gate_pin;
  assign reload_fall = tick && st_r.reload_sample && !pins.ext_reload_pin;
  assign count_plus = st_r.count + 16'h0001;

  // Increment decision per input select
  always_comb begin
    inc = 1'b0;
    unique case (insel)
      timer2_pkg::INSEL_STOP: inc = 1'b0;
      timer2_pkg::INSEL_TIMER: inc = tick && (!st_r.control[timer2_pkg::CTL_PRESCALE_BIT] || st_r.prescale_toggle);
      // increment one machine cycle after detection
      timer2_pkg::INSEL_COUNTER: inc = tick && st_r.count_edge_seen;
      // gate sample taken last machine cycle
      timer2_pkg::INSEL_GATED: inc = tick && st_r.gate_sample;
    endcase
  end
  assign rollover = inc && (st_r.count == timer2_pkg::COUNT_ONES);

  // Next-state logic for the whole block
  always_comb begin
    st_nxt = st_r;
    st_nxt.phase = tick ? 3'h0 : st_r.phase + 3'h1;
    if (tick) begin
      // toggle selects every second machine cycle
      st_nxt.prescale_toggle = !st_r.prescale_toggle;
      // gate sampled once per machine cycle
      st_nxt.gate_sample = pins.count_gate_pin;
      // sampling per machine cycle bounds the rate
      st_nxt.count_sample = pins.count_gate_pin;
      st_nxt.reload_sample = pins.ext_reload_pin;
      st_nxt.cap_sample = pins.capture_pin;
      st_nxt.count_edge_seen = count_fall;
      st_nxt.reload_edge_seen = reload_fall;
    end
    // count advances as one 16-bit value
    if (inc)
      st_nxt.count = count_plus;
    if (rollover)
      st_nxt.overflow_flag = 1'b1;
    // overflow reload overwrites zero in same cycle
    if (rollover && rmode == timer2_pkg::RELOAD_OVF)
      st_nxt.count = st_r.chan[0];
    // pin reload happens regardless of enable
    if (tick && st_r.reload_edge_seen && rmode == timer2_pkg::RELOAD_PIN)
      st_nxt.count = st_r.chan[0];
    // Software access to registers
    if (bus.wr) begin
      unique case (bus.addr)
        timer2_pkg::ADDR_COUNT_LOW: st_nxt.count[7:0] = bus.wdata;
        timer2_pkg::ADDR_COUNT_HIGH: st_nxt.count[15:8] = bus.wdata;
        // reload low byte is channel zero data
        timer2_pkg::ADDR_RELOAD_LOW: st_nxt.chan[0][7:0] = bus.wdata;
        timer2_pkg::ADDR_RELOAD_HIGH: st_nxt.chan[0][15:8] = bus.wdata;
        timer2_pkg::ADDR_CHAN1_LOW: st_nxt.chan[1][7:0] = bus.wdata;
        timer2_pkg::ADDR_CHAN1_HIGH: st_nxt.chan[1][15:8] = bus.wdata;
        timer2_pkg::ADDR_CHAN2_LOW: st_nxt.chan[2][7:0] = bus.wdata;
        timer2_pkg::ADDR_CHAN2_HIGH: st_nxt.chan[2][15:8] = bus.wdata;
        timer2_pkg::ADDR_CHAN3_LOW: st_nxt.chan[3][7:0] = bus.wdata;
        timer2_pkg::ADDR_CHAN3_HIGH: st_nxt.chan[3][15:8] = bus.wdata;
        timer2_pkg::ADDR_CONTROL: st_nxt.control = bus.wdata;
        timer2_pkg::ADDR_CHAN_MODE: st_nxt.chan_mode = bus.wdata;
        timer2_pkg::ADDR_IRQ_CTRL: begin
          st_nxt.timer_irq_enable = bus.wdata[timer2_pkg::IRQ_TIMER_EN_BIT];
          st_nxt.ext_reload_irq_enable = bus.wdata[timer2_pkg::IRQ_EXT_EN_BIT];
          // software clears flags; hardware set wins
          st_nxt.ext_reload_flag = bus.wdata[timer2_pkg::IRQ_EXT_FLAG_BIT];
          st_nxt.overflow_flag = bus.wdata[timer2_pkg::IRQ_OVF_FLAG_BIT];
        end
        default: ;
      endcase
    end
    // set after software write so set wins
    if (rollover)
      st_nxt.overflow_flag = 1'b1;
    // pin reload sets flag only when enabled
    if (tick && st_r.reload_edge_seen && rmode == timer2_pkg::RELOAD_PIN && st_r.ext_reload_irq_enable)
      st_nxt.ext_reload_flag = 1'b1;
    // Captures, after bus writes so a capture beats a same-cycle byte write
    for (int n = 0; n < 4; n++) begin
      // channel mode decode, write capture on low byte
      if (chan_mode_of(st_r.chan_mode, n) == timer2_pkg::CC_WRITE && bus.wr &&
          bus.addr == 4'(timer2_pkg::ADDR_RELOAD_LOW + 4'(2 * n)))
        st_nxt.chan[n] = st_r.count;
      if (chan_mode_of(st_r.chan_mode, n) == timer2_pkg::CC_EDGE && tick) begin
        if (n == 0) begin
          // edge select chooses rising or falling
          if (st_r.control[timer2_pkg::CTL_EDGE_BIT] ? (!st_r.cap_sample[0] && pins.capture_pin[0])
              : (st_r.cap_sample[0] && !pins.capture_pin[0]))
            st_nxt.chan[0] = st_r.count;
        end else if (!st_r.cap_sample[n] && pins.capture_pin[n]) begin
          // rising edge capture for channels 1-3
          st_nxt.chan[n] = st_r.count;
        end
      end
    end
    // Read data, valid the cycle after the strobe
    st_nxt.rdata = timer2_pkg::BYTE_ZERO;
    if (bus.rd) begin
      unique case (bus.addr)
        timer2_pkg::ADDR_COUNT_LOW: st_nxt.rdata = st_r.count[7:0];
        timer2_pkg::ADDR_COUNT_HIGH: st_nxt.rdata = st_r.count[15:8];
        timer2_pkg::ADDR_RELOAD_LOW: st_nxt.rdata = st_r.chan[0][7:0];
        timer2_pkg::ADDR_RELOAD_HIGH: st_nxt.rdata = st_r.chan[0][15:8];
        timer2_pkg::ADDR_CHAN1_LOW: st_nxt.rdata = st_r.chan[1][7:0];
        timer2_pkg::ADDR_CHAN1_HIGH: st_nxt.rdata = st_r.chan[1][15:8];
        timer2_pkg::ADDR_CHAN2_LOW: st_nxt.rdata = st_r.chan[2][7:0];
        timer2_pkg::ADDR_CHAN2_HIGH: st_nxt.rdata = st_r.chan[2][15:8];
        timer2_pkg::ADDR_CHAN3_LOW: st_nxt.rdata = st_r.chan[3][7:0];
        timer2_pkg::ADDR_CHAN3_HIGH: st_nxt.rdata = st_r.chan[3][15:8];
        timer2_pkg::ADDR_CONTROL: st_nxt.rdata = st_r.control;
        timer2_pkg::ADDR_CHAN_MODE: st_nxt.rdata = st_r.chan_mode;
        timer2_pkg::ADDR_IRQ_CTRL: st_nxt.rdata = {4'h0, st_r.overflow_flag, st_r.ext_reload_flag,
                                                   st_r.ext_reload_irq_enable, st_r.timer_irq_enable};
        // Unmapped addresses read as zero
        default: st_nxt.rdata = timer2_pkg::BYTE_ZERO;
      endcase
    end
  end

  // State register; reset clears everything
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign rdata = st_r.rdata;
  // enable gates both flags onto the request
  assign irq = st_r.timer_irq_enable && (st_r.overflow_flag || st_r.ext_reload_flag);

  // Compare output, active while count equals enabled register
  generate
    for (genvar g = 0; g < 4; g++) begin : g_cmp
      // compare mode enables the match signal
      assign compare_match[g] = (st_r.chan_mode[2*g +: 2] == timer2_pkg::CC_COMPARE) && (st_r.count == st_r.chan[g]);
    end
  endgenerate

  // Checks watch the registered state; reset masks them while resetn is low
  // no request without enable
  chk_irq_blocked: assert property (@(posedge clk) disable iff (!resetn)
    !st_r.timer_irq_enable |-> !irq)
    else $error("irq high with enable clear");

  chk_irq_idle: assert property (@(posedge clk) disable iff (!resetn)
    !st_r.overflow_flag && !st_r.ext_reload_flag |-> !irq)
    else $error("irq high with both flags clear");

  chk_ovf_sets: assert property (@(posedge clk) disable iff (!resetn)
    rollover |=> st_r.overflow_flag)
    else $error("overflow flag not set on rollover");

  chk_ovf_sticky: assert property (@(posedge clk) disable iff (!resetn)
    st_r.overflow_flag && !(bus.wr && bus.addr == timer2_pkg::ADDR_IRQ_CTRL) |=> st_r.overflow_flag)
    else $error("overflow flag cleared by hardware");

  chk_ovf_irq: assert property (@(posedge clk) disable iff (!resetn)
    st_r.timer_irq_enable && st_r.overflow_flag |-> irq)
    else $error("overflow flag did not request");

  chk_ext_flag_sticky: assert property (@(posedge clk) disable iff (!resetn)
    st_r.ext_reload_flag && !(bus.wr && bus.addr == timer2_pkg::ADDR_IRQ_CTRL) |=> st_r.ext_reload_flag)
    else $error("reload flag cleared by hardware");

  chk_ext_flag_set: assert property (@(posedge clk) disable iff (!resetn)
    tick && st_r.reload_edge_seen && rmode == timer2_pkg::RELOAD_PIN && st_r.ext_reload_irq_enable
    |=> st_r.ext_reload_flag)
    else $error("reload flag not set on pin reload");

  chk_ext_flag_quiet: assert property (@(posedge clk) disable iff (!resetn)
    !st_r.ext_reload_irq_enable && !st_r.ext_reload_flag && !(bus.wr && bus.addr == timer2_pkg::ADDR_IRQ_CTRL)
    |=> !st_r.ext_reload_flag)
    else $error("reload flag set with its enable clear");

  chk_pin_reload: assert property (@(posedge clk) disable iff (!resetn)
    tick && st_r.reload_edge_seen && rmode == timer2_pkg::RELOAD_PIN && !bus.wr |=> st_r.count == $past(st_r.chan[0]))
    else $error("pin reload missed");

  chk_ovf_reload: assert property (@(posedge clk) disable iff (!resetn)
    rollover && rmode == timer2_pkg::RELOAD_OVF && !bus.wr |=> st_r.count == $past(st_r.chan[0]))
    else $error("overflow reload missed");

  chk_stop_holds: assert property (@(posedge clk) disable iff (!resetn)
    insel == timer2_pkg::INSEL_STOP && !bus.wr && !st_r.reload_edge_seen |=> st_r.count == $past(st_r.count))
    else $error("stopped timer changed");

  chk_tick_period: assert property (@(posedge clk) disable iff (!resetn)
    tick |-> ##6 tick)
    else $error("machine tick not six clocks apart");

  chk_inc_on_tick: assert property (@(posedge clk) disable iff (!resetn)
    inc |-> tick)
    else $error("count advanced between machine ticks");

  chk_timer_rate: assert property (@(posedge clk) disable iff (!resetn)
    insel == timer2_pkg::INSEL_TIMER && !st_r.control[timer2_pkg::CTL_PRESCALE_BIT] && tick |-> inc)
    else $error("timer skipped a machine cycle");

  chk_prescale_rate: assert property (@(posedge clk) disable iff (!resetn)
    insel == timer2_pkg::INSEL_TIMER && st_r.control[timer2_pkg::CTL_PRESCALE_BIT] && inc |-> ##6 !inc)
    else $error("prescaled timer counted in consecutive machine cycles");

  chk_count_step: assert property (@(posedge clk) disable iff (!resetn)
    inc && !rollover && !bus.wr && !(st_r.reload_edge_seen && rmode == timer2_pkg::RELOAD_PIN)
    |=> st_r.count == $past(st_r.count) + 16'h0001)
    else $error("count did not step by one");

  chk_gate_low: assert property (@(posedge clk) disable iff (!resetn)
    insel == timer2_pkg::INSEL_GATED && !st_r.gate_sample |-> !inc)
    else $error("gated timer counted with gate low");

  chk_gate_high: assert property (@(posedge clk) disable iff (!resetn)
    insel == timer2_pkg::INSEL_GATED && tick && st_r.gate_sample |-> inc)
    else $error("gated timer idle with gate high");

  chk_count_edge: assert property (@(posedge clk) disable iff (!resetn)
    insel == timer2_pkg::INSEL_COUNTER && count_fall |-> ##6 inc)
    else $error("count edge not counted next machine cycle");

  chk_count_quiet: assert property (@(posedge clk) disable iff (!resetn)
    insel == timer2_pkg::INSEL_COUNTER && !st_r.count_edge_seen |-> !inc)
    else $error("counter advanced without an edge");

  chk_read_data: assert property (@(posedge clk) disable iff (!resetn)
    bus.rd && bus.addr == timer2_pkg::ADDR_COUNT_HIGH |=> rdata == $past(st_r.count[15:8]))
    else $error("count high byte read wrong");

  chk_read_low: assert property (@(posedge clk) disable iff (!resetn)
    bus.rd && bus.addr == timer2_pkg::ADDR_COUNT_LOW |=> rdata == $past(st_r.count[7:0]))
    else $error("count low byte read wrong");

  chk_read_reload: assert property (@(posedge clk) disable iff (!resetn)
    bus.rd && bus.addr == timer2_pkg::ADDR_RELOAD_HIGH |=> rdata == $past(st_r.chan[0][15:8]))
    else $error("reload high byte read wrong");

  chk_read_idle: assert property (@(posedge clk) disable iff (!resetn)
    !bus.rd |=> rdata == timer2_pkg::BYTE_ZERO)
    else $error("read data stood without a read");

  chk_ext_irq: assert property (@(posedge clk) disable iff (!resetn)
    st_r.timer_irq_enable && st_r.ext_reload_flag |-> irq)
    else $error("reload flag did not request");

  chk_write_capture: assert property (@(posedge clk) disable iff (!resetn)
    chan_mode_of(st_r.chan_mode, 1) == timer2_pkg::CC_WRITE && bus.wr && bus.addr == timer2_pkg::ADDR_CHAN1_LOW
    |=> st_r.chan[1] == $past(st_r.count))
    else $error("write capture missed");

  chk_rise_capture: assert property (@(posedge clk) disable iff (!resetn)
    chan_mode_of(st_r.chan_mode, 2) == timer2_pkg::CC_EDGE && tick && !st_r.cap_sample[2] && pins.capture_pin[2]
    |=> st_r.chan[2] == $past(st_r.count))
    else $error("rising edge capture missed");

  cov_rollover: cover property (@(posedge clk) disable iff (!resetn) rollover);
  cov_pin_reload: cover property (@(posedge clk) disable iff (!resetn) st_r.ext_reload_flag);
  cov_count_mode: cover property (@(posedge clk) disable iff (!resetn) insel == timer2_pkg::INSEL_COUNTER && inc);
  cov_irq: cover property (@(posedge clk) disable iff (!resetn) irq);
  cov_edge_capture: cover property (@(posedge clk) disable iff (!resetn)
    chan_mode_of(st_r.chan_mode, 0) == timer2_pkg::CC_EDGE && tick && st_r.cap_sample[0] != pins.capture_pin[0]);
endmodule

// ---- hw/timer2_pkg.sv ----
// Package with register map, field positions and timing constants of the timer block
package timer2_pkg;
  // Register indices on the plain register port
  localparam logic [3:0] ADDR_COUNT_LOW = 4'h0;
  localparam logic [3:0] ADDR_COUNT_HIGH = 4'h1;
  localparam logic [3:0] ADDR_RELOAD_LOW = 4'h2;
  localparam logic [3:0] ADDR_RELOAD_HIGH = 4'h3;
  localparam logic [3:0] ADDR_CHAN1_LOW = 4'h4;
  localparam logic [3:0] ADDR_CHAN1_HIGH = 4'h5;
  localparam logic [3:0] ADDR_CHAN2_LOW = 4'h6;
  localparam logic [3:0] ADDR_CHAN2_HIGH = 4'h7;
  localparam logic [3:0] ADDR_CHAN3_LOW = 4'h8;
  localparam logic [3:0] ADDR_CHAN3_HIGH = 4'h9;
  localparam logic [3:0] ADDR_CONTROL = 4'hA;
  localparam logic [3:0] ADDR_CHAN_MODE = 4'hB;
  localparam logic [3:0] ADDR_IRQ_CTRL = 4'hC;
  // Control register fields
  localparam int CTL_INSEL_LSB = 0;
  localparam int CTL_RELOAD_LSB = 3;
  localparam int CTL_EDGE_BIT = 5;
  localparam int CTL_PRESCALE_BIT = 7;
  // Interrupt control fields
  localparam int IRQ_TIMER_EN_BIT = 0;
  localparam int IRQ_EXT_EN_BIT = 1;
  localparam int IRQ_EXT_FLAG_BIT = 2;
  localparam int IRQ_OVF_FLAG_BIT = 3;
  // Mode field codes
  localparam logic [1:0] INSEL_STOP = 2'h0;
  localparam logic [1:0] INSEL_TIMER = 2'h1;
  localparam logic [1:0] INSEL_COUNTER = 2'h2;
  localparam logic [1:0] INSEL_GATED = 2'h3;
  localparam logic [1:0] CC_OFF = 2'h0;
  localparam logic [1:0] CC_EDGE = 2'h1;
  localparam logic [1:0] CC_COMPARE = 2'h2;
  localparam logic [1:0] CC_WRITE = 2'h3;
  localparam logic [1:0] RELOAD_OVF = 2'h2;
  localparam logic [1:0] RELOAD_PIN = 2'h3;
  // Timing: oscillator periods per machine cycle
  localparam int OSC_PER_MACHINE = 6;
  localparam int CLK_PER_OSC = 1;
  localparam int MACHINE_CLKS = OSC_PER_MACHINE * CLK_PER_OSC;
  localparam logic [2:0] MACHINE_LAST = 3'(MACHINE_CLKS - 1);
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] COUNT_ONES = 16'hFFFF;

  // Register bus request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  // External pins
  typedef struct packed {
    logic count_gate_pin;
    logic ext_reload_pin;
    logic [3:0] capture_pin;
  } pins_t;

  // Whole block state
  typedef struct packed {
    logic [2:0] phase;
    logic prescale_toggle;
    logic [15:0] count;
    logic [3:0][15:0] chan;
    logic [7:0] control;
    logic [7:0] chan_mode;
    logic timer_irq_enable;
    logic ext_reload_irq_enable;
    logic ext_reload_flag;
    logic overflow_flag;
    logic gate_sample;
    logic count_sample;
    logic reload_sample;
    logic [3:0] cap_sample;
    logic count_edge_seen;
    logic reload_edge_seen;
    logic [7:0] rdata;
  } state_t;
endpackage

// ---- verif/timer2_counter_reload_capture_tb.sv ----
// Self-checking testbench of the timer block with its pin partner
`timescale 1ns/1ps
module timer2_counter_reload_capture_tb;
  logic clk = 1'b0; // 25 MHz clock
  logic resetn = 1'b0; // Held low at start
  timer2_pkg::bus_req_t bus = '0; // Register bus request
  timer2_pkg::pins_t pins; // Driven by the partner
  logic [7:0] rdata;
  logic irq;
  logic [3:0] compare_match;
  int num_errors = 0;
  int samples_checked = 0;
  logic [7:0] rd_val; // Last byte read
  logic [7:0] first; // Earlier count sample

  // Half period of 20 ns
  always #20 clk = ~clk;

  timer2_counter_reload_capture dut (.clk(clk), .resetn(resetn), .bus(bus), .rdata(rdata), .pins(pins),
    .irq(irq), .compare_match(compare_match));
  timer2_pin_model partner (.clk(clk), .pins(pins));

  // Compare one byte and count it
  task automatic check(input logic [7:0] seen, input logic [7:0] want, input string what);
    samples_checked++;
    if (seen !== want) begin
      num_errors++;
      $display("wrong value at %0t: %s saw %h expected %h", $time, what, seen, want);
    end
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  // One-cycle read strobe; data taken in the following cycle only
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    rd_val = rdata;
  endtask

  // Count advance over exactly sixty clocks between the two sampling edges
  task automatic rate(input logic [7:0] ctl, input logic [7:0] want);
    wr(timer2_pkg::ADDR_CONTROL, ctl);
    rd(timer2_pkg::ADDR_COUNT_LOW);
    first = rd_val;
    repeat (58) @(posedge clk);
    rd(timer2_pkg::ADDR_COUNT_LOW);
    check(rd_val - first, want, "count advance");
  endtask

  // Reset values, read-write bytes and an unmapped index
  task automatic regs_after_reset();
    for (int a = 0; a < 13; a++) begin
      rd(4'(a));
      check(rd_val, 8'h00, "reset value");
    end
    wr(4'hF, 8'hA5);
    rd(4'hF);
    check(rd_val, 8'h00, "unmapped read");
    wr(timer2_pkg::ADDR_COUNT_LOW, 8'h5A);
    wr(timer2_pkg::ADDR_COUNT_HIGH, 8'hC3);
    wr(timer2_pkg::ADDR_RELOAD_HIGH, 8'hA5);
    rd(timer2_pkg::ADDR_COUNT_LOW);
    check(rd_val, 8'h5A, "count low");
    rd(timer2_pkg::ADDR_COUNT_HIGH);
    check(rd_val, 8'hC3, "count high");
    rd(timer2_pkg::ADDR_RELOAD_HIGH);
    check(rd_val, 8'hA5, "reload high");
  endtask

  // Timer, prescaled, stopped, gated and event counting rates
  task automatic count_rates();
    rate(8'h01, 8'h0A);
    rate(8'h81, 8'h05);
    rate(8'h00, 8'h00);
    rate(8'h03, 8'h0A);
    partner.drive(0, 1'b0);
    rate(8'h03, 8'h00);
    partner.drive(0, 1'b1);
    wr(timer2_pkg::ADDR_CONTROL, 8'h02);
    rd(timer2_pkg::ADDR_COUNT_LOW);
    first = rd_val;
    for (int i = 0; i < 3; i++) begin
      partner.drive(0, 1'b0);
      partner.drive(0, 1'b1);
    end
    rd(timer2_pkg::ADDR_COUNT_LOW);
    check(rd_val - first, 8'h03, "edge count");
  endtask

  // Rollover with reload mode codes 0 to 2, flag and interrupt
  task automatic overflow_reload();
    wr(timer2_pkg::ADDR_RELOAD_LOW, 8'h34);
    wr(timer2_pkg::ADDR_RELOAD_HIGH, 8'h12);
    for (int m = 0; m < 3; m++) begin
      wr(timer2_pkg::ADDR_CONTROL, 8'h00);
      wr(timer2_pkg::ADDR_IRQ_CTRL, 8'h01);
      wr(timer2_pkg::ADDR_COUNT_LOW, 8'hFF);
      wr(timer2_pkg::ADDR_COUNT_HIGH, 8'hFF);
      wr(timer2_pkg::ADDR_CONTROL, 8'h01 | 8'(m << 3));
      repeat (12) @(posedge clk);
      rd(timer2_pkg::ADDR_COUNT_HIGH);
      check(rd_val, (m == 2) ? 8'h12 : 8'h00, "count after rollover");
      rd(timer2_pkg::ADDR_IRQ_CTRL);
      check(rd_val, 8'h09, "overflow flag");
      check({7'h00, irq}, 8'h01, "irq enabled");
      wr(timer2_pkg::ADDR_IRQ_CTRL, 8'h08);
      #1;
      check({7'h00, irq}, 8'h00, "irq blocked");
      wr(timer2_pkg::ADDR_IRQ_CTRL, 8'h00);
    end
  endtask

  // Pin falling edge reloads whatever the flag enable; flag only when enabled
  task automatic pin_reload();
    for (int en = 0; en < 2; en++) begin
      wr(timer2_pkg::ADDR_CONTROL, 8'h00);
      wr(timer2_pkg::ADDR_COUNT_HIGH, 8'h00);
      wr(timer2_pkg::ADDR_IRQ_CTRL, 8'h01 | 8'(en << 1));
      wr(timer2_pkg::ADDR_CONTROL, 8'h19);
      partner.drive(1, 1'b0);
      partner.drive(1, 1'b1);
      rd(timer2_pkg::ADDR_COUNT_HIGH);
      check(rd_val, 8'h12, "pin reload");
      rd(timer2_pkg::ADDR_IRQ_CTRL);
      check(rd_val, en ? 8'h07 : 8'h01, "reload flag");
      check({7'h00, irq}, 8'(en), "flag irq");
      wr(timer2_pkg::ADDR_IRQ_CTRL, 8'h00);
    end
  endtask

  // Edge and write modes of all four channels, compare mode of channel 1
  task automatic channels();
    logic [7:0] cnt [4] = '{8'h55, 8'h66, 8'h77, 8'h88};
    logic [7:0] exp [4] = '{8'h55, 8'h55, 8'h55, 8'h88};
    wr(timer2_pkg::ADDR_CHAN_MODE, 8'h01);
    for (int s = 0; s < 4; s++) begin
      wr(timer2_pkg::ADDR_CONTROL, (s < 2) ? 8'h20 : 8'h00);
      wr(timer2_pkg::ADDR_COUNT_LOW, cnt[s]);
      partner.drive(2, (s % 2) == 0);
      rd(timer2_pkg::ADDR_RELOAD_LOW);
      check(rd_val, exp[s], "edge capture");
    end
    for (int n = 1; n < 4; n++) begin
      wr(timer2_pkg::ADDR_CHAN_MODE, 8'(8'h01 << (2 * n)));
      wr(timer2_pkg::ADDR_COUNT_LOW, 8'(8'h40 + n));
      partner.drive(2 + n, 1'b1);
      rd(4'(2 + 2 * n));
      check(rd_val, 8'(8'h40 + n), "rising capture");
      partner.drive(2 + n, 1'b0);
    end
    wr(timer2_pkg::ADDR_CHAN_MODE, 8'hFF);
    wr(timer2_pkg::ADDR_COUNT_LOW, 8'h99);
    for (int n = 0; n < 4; n++) begin
      wr(4'(2 + 2 * n), 8'h00);
      rd(4'(2 + 2 * n));
      check(rd_val, 8'h99, "write capture");
    end
    wr(timer2_pkg::ADDR_CHAN_MODE, 8'h08);
    wr(timer2_pkg::ADDR_CHAN1_HIGH, 8'h00);
    wr(timer2_pkg::ADDR_COUNT_HIGH, 8'h00);
    @(posedge clk);
    #1;
    check({4'h0, compare_match}, 8'h02, "compare match");
    wr(timer2_pkg::ADDR_COUNT_LOW, 8'h98);
    #1;
    check({4'h0, compare_match}, 8'h00, "compare miss");
  endtask

  // Verdict and end of run
  task automatic end_of_test();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Cuts a hang short
  initial begin
    #4000000;
    num_errors++;
    end_of_test();
  end

  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    regs_after_reset();
    count_rates();
    overflow_reload();
    pin_reload();
    channels();
    end_of_test();
  end
endmodule

// ---- verif/timer2_pin_model.sv ----
// Behavioural model of the external count, gate, reload and capture pins
`timescale 1ns/1ps
module timer2_pin_model (
  input wire logic clk,
  output timer2_pkg::pins_t pins
);
  // Gate and reload idle high, capture inputs idle low
  initial begin
    pins = '{count_gate_pin: 1'b1, ext_reload_pin: 1'b1, capture_pin: 4'h0};
  end

  // level held long
  // Each level lands just after an edge and stands twelve clocks, two machine cycles,
  // so the block samples it at least once whatever the tick phase
  task automatic drive(input int which, input logic level);
    @(posedge clk);
    case (which)
      0: pins.count_gate_pin <= level;
      1: pins.ext_reload_pin <= level;
      default: pins.capture_pin[which - 2] <= level;
    endcase
    repeat (12) @(posedge clk);
  endtask
endmodule
